// [design/cfg_sync.v]
/*
  Two-flop synchroniser for the port-count strap pin.
  Assumes the strap is quasi-static.
*/
`timescale 1ns/100ps
module cfg_sync (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire async_i,
  output reg sync_o
);
  reg stage1;

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage1 <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

// [design/port_power_sel.v]
/*
  One downstream port's power state, steered by global or per-port commands.
  Assumes command strobes are one-cycle pulses on sys_clk_i.
*/
`timescale 1ns/100ps
module port_power_sel (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire no_switching_i,
  input wire individual_mode_i,
  input wire mask_i,
  input wire global_set_i,
  input wire global_clr_i,
  input wire port_set_i,
  input wire port_clr_i,
  output reg power_o
);
  wire per_port;
  assign per_port = individual_mode_i & mask_i;

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      power_o <= 1'b0;
    end else if (no_switching_i) begin
      power_o <= 1'b1;
    end else if (per_port) begin
      if (port_set_i) begin
        power_o <= 1'b1;
      end else if (port_clr_i) begin
        power_o <= 1'b0;
      end
    end else begin
      if (global_set_i) begin
        power_o <= 1'b1;
      end else if (global_clr_i) begin
        power_o <= 1'b0;
      end
    end
  end
endmodule

// [design/rh_desc_regs.vh]
/*
  Offsets, field positions, reset values and port counts of the first
  root hub descriptor register.
  Assumes inclusion by bare name from the design files.
*/
`ifndef RH_DESC_REGS_VH
`define RH_DESC_REGS_VH

`define ROOT_HUB_DESCRIPTOR_FIRST_OFFSET 8'h48
`define FLD_WAIT_MSB 31
`define FLD_WAIT_LSB 24
`define FLD_PROT_ABSENT 12
`define FLD_OC_MODE 11
`define FLD_COMPOUND 10
`define FLD_NO_SWITCH 9
`define FLD_SWITCH_MODE 8
`define RST_WAIT 8'hFF
`define RST_PROT_ABSENT 1'h0
`define RST_NO_SWITCH 1'h0
`define RST_SWITCH_MODE 1'h1
`define COMPOUND_VALUE 1'h0
`define PORT_COUNT_TWO 8'h02
`define PORT_COUNT_ONE 8'h01
`define WAIT_UNIT_MS 2
`define NUM_PORTS 2

`endif

// [design/root_hub_descriptor_a.v]
/*
  First root hub descriptor register at offset 48h, with the per-port
  power steering that its switching bits control.
  Assumes a simple single-cycle register port on sys_clk_i, byte enables
  per lane, a mask and power commands from neighbouring hub logic, and a
  strap pin selecting one or two ports.
*/
`timescale 1ns/100ps
`include "rh_desc_regs.vh"
module root_hub_descriptor_a (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire reg_sel_i,
  input wire reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire [3:0] reg_be_i,
  input wire [31:0] reg_wdata_i,
  output reg [31:0] reg_rdata_o,
  input wire two_port_cfg_i,
  input wire [`NUM_PORTS:1] per_port_power_mask_i,
  input wire global_power_set_i,
  input wire global_power_clr_i,
  input wire [`NUM_PORTS:1] port_power_set_i,
  input wire [`NUM_PORTS:1] port_power_clr_i,
  output wire [`NUM_PORTS:1] port_power_o,
  output wire port_enabled2_o,
  output wire overcurrent_per_port_o,
  output wire overcurrent_enabled_o
);
  // -----------------------------------------------------------------
  // Register fields
  // -----------------------------------------------------------------
  reg [7:0] power_good_wait;
  reg protection_absent;
  reg overcurrent_report_mode;
  reg no_switching_flag;
  reg power_switching_mode;
  wire two_port;
  wire hit;
  wire wr;
  wire [7:0] port_count;
  wire [31:0] rd_word;

  cfg_sync u_cfg_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(two_port_cfg_i),
    .sync_o(two_port)
  );

  assign hit = reg_sel_i & (reg_addr_i == `ROOT_HUB_DESCRIPTOR_FIRST_OFFSET);
  assign wr = hit & reg_wr_i;
  assign port_count = two_port ? `PORT_COUNT_TWO : `PORT_COUNT_ONE;

  // -----------------------------------------------------------------
  // Writes
  // -----------------------------------------------------------------
  // Reporting bit resets to the switching mode reset value, so both agree.
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      power_good_wait <= `RST_WAIT;
      protection_absent <= `RST_PROT_ABSENT;
      overcurrent_report_mode <= `RST_SWITCH_MODE;
      no_switching_flag <= `RST_NO_SWITCH;
      power_switching_mode <= `RST_SWITCH_MODE;
    end else if (wr) begin
      if (reg_be_i[3]) begin
        power_good_wait <= reg_wdata_i[`FLD_WAIT_MSB:`FLD_WAIT_LSB];
      end
      if (reg_be_i[1]) begin
        protection_absent <= reg_wdata_i[`FLD_PROT_ABSENT];
        overcurrent_report_mode <= reg_wdata_i[`FLD_OC_MODE];
        no_switching_flag <= reg_wdata_i[`FLD_NO_SWITCH];
        power_switching_mode <= reg_wdata_i[`FLD_SWITCH_MODE];
      end
      // Byte 0, byte 2 and bit 10 have no storage: writes drop away.
    end
  end

  // -----------------------------------------------------------------
  // Reads
  // -----------------------------------------------------------------
  assign rd_word = {power_good_wait, 11'h000, protection_absent,
                    overcurrent_report_mode, `COMPOUND_VALUE, no_switching_flag,
                    power_switching_mode, port_count};

  // Unmapped addresses read zero.
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_sel_i & ~reg_wr_i) begin
      reg_rdata_o <= hit ? rd_word : 32'h00000000;
    end
  end

  // -----------------------------------------------------------------
  // Port power and overcurrent scheme
  // -----------------------------------------------------------------
  // Overcurrent mode only counts while protection is present.
  assign overcurrent_enabled_o = ~protection_absent;
  assign overcurrent_per_port_o = ~protection_absent & overcurrent_report_mode;
  // Port 2 is enabled only while the synchronised strap selects two ports.
  assign port_enabled2_o = two_port;

  genvar p;
  generate
    for (p = 1; p <= `NUM_PORTS; p = p + 1) begin : g_port
      port_power_sel u_port (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .no_switching_i(no_switching_flag),
        .individual_mode_i(power_switching_mode),
        .mask_i(per_port_power_mask_i[p]),
        .global_set_i(global_power_set_i),
        .global_clr_i(global_power_clr_i),
        .port_set_i(port_power_set_i[p]),
        .port_clr_i(port_power_clr_i[p]),
        .power_o(port_power_o[p])
      );
    end
  endgenerate
endmodule

// [test/root_hub_descriptor_a_props.sv]
/* Port checks for the first root hub descriptor register.
   Assumes one clock and bind onto the design top. */
`timescale 1ns/100ps
module rh_desc_chk (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire reg_sel_i,
  input wire reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_rdata_o,
  input wire global_power_set_i,
  input wire global_power_clr_i,
  input wire [2:1] port_power_set_i,
  input wire [2:1] port_power_clr_i,
  input wire [2:1] port_power_o,
  input wire port_enabled2_o,
  input wire overcurrent_per_port_o,
  input wire overcurrent_enabled_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  wire rd = reg_sel_i && !reg_wr_i;
  wire hit = rd && reg_addr_i == 8'h48;
  wire quiet = !(reg_sel_i && reg_wr_i) && !global_power_set_i && !global_power_clr_i
    && port_power_set_i == 2'h0 && port_power_clr_i == 2'h0;
  oc_enable_a: assert property (hit |=> reg_rdata_o[12] != overcurrent_enabled_o)
    else $error("oc enable");
  oc_mode_a: assert property (hit |=> overcurrent_per_port_o == (!reg_rdata_o[12] && reg_rdata_o[11]))
    else $error("oc mode");
  compound_zero_a: assert property (hit |=> !reg_rdata_o[10])
    else $error("compound");
  reserved_zero_a: assert property (hit |=> reg_rdata_o[23:13] == 11'h000)
    else $error("reserved");
  port_count_a: assert property (hit |=> reg_rdata_o[7:0] == ($past(port_enabled2_o) ? 8'h02 : 8'h01))
    else $error("port count");
  unmapped_zero_a: assert property (rd && reg_addr_i != 8'h48 |=> reg_rdata_o == 32'h0)
    else $error("unmapped");
  always_on_a: assert property (hit ##1 reg_rdata_o[9] |-> port_power_o == 2'h3)
    else $error("always on");
  power_hold_a: assert property (quiet && $past(quiet) && $past(quiet, 2) |=> $stable(port_power_o))
    else $error("power hold");
endmodule
bind root_hub_descriptor_a rh_desc_chk rh_desc_chk_inst (.sys_clk_i, .rstn_i, .reg_sel_i,
  .reg_wr_i, .reg_addr_i, .reg_rdata_o, .global_power_set_i, .global_power_clr_i,
  .port_power_set_i, .port_power_clr_i, .port_power_o, .port_enabled2_o,
  .overcurrent_per_port_o, .overcurrent_enabled_o);

// [test/test_root_hub_descriptor_a.sv]
/* Register and power steering tests for the descriptor block.
   Assumes the design top and its checker are compiled alongside. */
`timescale 1ns/100ps
module test_root_hub_descriptor_a;
  reg sys_clk_i = 0;
  reg rstn_i = 0;
  reg sel = 0;
  reg wr = 0;
  reg strap = 0;
  reg gs = 0;
  reg gc = 0;
  reg [7:0] addr = 8'h48;
  reg [3:0] be = 4'h0;
  reg [31:0] wd = 32'h0;
  reg [31:0] d;
  reg [2:1] ps = 2'h0;
  reg [2:1] pc = 2'h0;
  wire [31:0] rdata;
  wire [2:1] pwr;
  wire pe2;
  wire ocpp;
  wire ocen;
  integer errors = 0;
  integer checks = 0;
  integer cyc = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      stop_test;
    end
  end
  root_hub_descriptor_a root_hub_descriptor_a_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .reg_sel_i(sel), .reg_wr_i(wr), .reg_addr_i(addr), .reg_be_i(be), .reg_wdata_i(wd),
    .reg_rdata_o(rdata), .two_port_cfg_i(strap), .per_port_power_mask_i(2'h2),
    .global_power_set_i(gs), .global_power_clr_i(gc), .port_power_set_i(ps),
    .port_power_clr_i(pc), .port_power_o(pwr), .port_enabled2_o(pe2),
    .overcurrent_per_port_o(ocpp), .overcurrent_enabled_o(ocen));
  task stop_test;
    begin
      if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task acc(input w, input [7:0] a, input [3:0] b, input [31:0] v);
    begin
      @(posedge sys_clk_i);
      {sel, wr, addr, be, wd} <= {1'h1, w, a, b, v};
      @(posedge sys_clk_i);
      sel <= 1'h0;
      #1 d = rdata;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      acc(1'h0, a, 4'h0, 32'h0);
      chk(d, e);
    end
  endtask
  // Command bits are {global set, global clear, port set, port clear}
  task cmd(input [5:0] c, input [1:0] e);
    begin
      @(posedge sys_clk_i);
      {gs, gc, ps, pc} <= c;
      @(posedge sys_clk_i);
      {gs, gc, ps, pc} <= 6'h00;
      // Settling gap only; the power-good wait itself is software's job
      repeat (3) @(posedge sys_clk_i);
      chk({30'h0, pwr}, {30'h0, e});
    end
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rstn_i <= 1'h1;
    repeat (3) @(posedge sys_clk_i);
    rd(8'h48, 32'hFF000901);
    chk({31'h0, ocen}, 32'h1);
    chk({31'h0, ocpp}, 32'h1);
    chk({31'h0, pe2}, 32'h0);
    strap <= 1'h1;
    repeat (3) @(posedge sys_clk_i);
    rd(8'h48, 32'hFF000902);
    chk({31'h0, pe2}, 32'h1);
    acc(1'h1, 8'h48, 4'hF, 32'hFFFFFFFF);
    rd(8'h48, 32'hFF001B02);
    cmd(6'h00, 2'h3);
    acc(1'h1, 8'h48, 4'h8, 32'h5A00FF00);
    rd(8'h48, 32'h5A001B02);
    acc(1'h1, 8'h48, 4'h2, 32'hFFFF1500);
    rd(8'h48, 32'h5A001502 & 32'hFFFFFBFF);
    acc(1'h1, 8'h4C, 4'hF, 32'hFFFFFFFF);
    rd(8'h4C, 32'h0);
    rd(8'h48, 32'h5A001102);
    chk({31'h0, ocen}, 32'h0);
    chk({31'h0, ocpp}, 32'h0);
    acc(1'h1, 8'h48, 4'h2, 32'h0);
    chk({31'h0, ocen}, 32'h1);
    chk({31'h0, ocpp}, 32'h0);
    cmd(6'h10, 2'h0);
    cmd(6'h0C, 2'h0);
    cmd(6'h20, 2'h3);
    cmd(6'h03, 2'h3);
    acc(1'h1, 8'h48, 4'h2, 32'h100);
    cmd(6'h10, 2'h2);
    cmd(6'h03, 2'h0);
    cmd(6'h0C, 2'h2);
    cmd(6'h20, 2'h3);
    stop_test;
  end
endmodule
